// [include/flash_seq_pkg.sv]
// Constants, register map and timing counts of the flash operation sequencer.
// Assumes a single 40 MHz system clock; all counts derive from its period.
package flash_seq_pkg;

    // System clock period
    localparam int CLK_PERIOD_NS = 25;

    // Timer width, covers the longest count below
    localparam int TMR_W = 12;

    // Documented times, in ns
    localparam int T_PSUS_TYP_NS = 9400;
    localparam int T_ESUS_TYP_NS = 16000;
    localparam int T_DONES_TYP_NS = 16000;
    localparam int T_DRCV_MIN_NS = 16000;
    localparam int T_AISTOP_MAX_NS = 80;
    localparam int T_MRSTOP_MIN_NS = 10360;

    // Added system clock periods
    localparam int PLUS_FOUR = 4;
    localparam int PLUS_SEVEN = 7;
    localparam int PLUS_FIFTEEN = 15;

    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_dn(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [TMR_W-1:0] PSUS_CYC = TMR_W'(cyc_up(T_PSUS_TYP_NS) + PLUS_FOUR);
    localparam logic [TMR_W-1:0] ESUS_CYC = TMR_W'(cyc_up(T_ESUS_TYP_NS) + PLUS_FOUR);
    localparam logic [TMR_W-1:0] ABORT_CYC = TMR_W'(cyc_up(T_DONES_TYP_NS) + PLUS_FOUR);
    localparam logic [TMR_W-1:0] RECOVER_CYC = TMR_W'(cyc_up(T_DRCV_MIN_NS) + PLUS_SEVEN);
    localparam logic [TMR_W-1:0] AI_STOP_CYC = TMR_W'(cyc_dn(T_AISTOP_MAX_NS) + PLUS_FIFTEEN);
    localparam logic [TMR_W-1:0] MR_STOP_CYC = TMR_W'(cyc_up(T_MRSTOP_MIN_NS) + PLUS_FOUR);

    // APB register byte offsets
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] OFF_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] OFF_CHECK = 8'h08;
    localparam logic [APB_AW-1:0] OFF_READCFG = 8'h0C;
    localparam logic [APB_AW-1:0] OFF_IRQ_STS = 8'h10;
    localparam logic [APB_AW-1:0] OFF_IRQ_MSK = 8'h14;

    // Operation control fields
    localparam int CTRL_W = 4;
    localparam int B_HVE = 0;
    localparam int B_PSUS = 1;
    localparam int B_ESUS = 2;
    localparam int B_LOWPWR = 3;

    // Integrity check control fields
    localparam int CHK_W = 4;
    localparam int B_AIE = 0;
    localparam int B_AISUS = 1;
    localparam int B_INTEGRITY_BREAKPOINT_NEGATE = 2;
    localparam int B_MARGIN = 3;

    // Status fields
    localparam int STS_W = 6;
    localparam int B_DONE = 0;
    localparam int B_AID = 1;
    localparam int B_READY = 2;
    localparam int B_OPBUSY = 3;
    localparam int B_CKBUSY = 4;
    localparam int B_INLP = 5;

    // Read configuration fields
    localparam int READ_WAIT_CYCLES_W = 3;
    localparam int B_APC = 3;

    // Interrupt events
    localparam int IRQ_W = 3;
    localparam int E_DONE = 0;
    localparam int E_AID = 1;
    localparam int E_RECOV = 2;

    typedef enum logic [6:0] {
        OP_IDLE = 7'b000_0001,
        OP_RUN = 7'b000_0010,
        OP_SUSPENDING = 7'b000_0100,
        OP_SUSPENDED = 7'b000_1000,
        OP_ABORTING = 7'b001_0000,
        OP_FINISHED = 7'b010_0000,
        OP_LOWPWR = 7'b100_0000
    } op_state_t;

    typedef enum logic [6:0] {
        CK_IDLE = 7'b000_0001,
        CK_RUN = 7'b000_0010,
        CK_SUSPENDING = 7'b000_0100,
        CK_SUSPENDED = 7'b000_1000,
        CK_ABORTING = 7'b001_0000,
        CK_BREAK = 7'b010_0000,
        CK_FINISHED = 7'b100_0000
    } ck_state_t;

endpackage

// [include/flash_timer_if.sv]
// Load/expire link between the sequencer and one delay timer.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface flash_timer_if;
    import flash_seq_pkg::*;
    logic load;
    logic [TMR_W-1:0] count;
    logic expire;
    modport ctl (output load, output count, input expire);
    modport tmr (input load, input count, output expire);
endinterface
`default_nettype wire

// [verif/flash_op_control_timing_properties.sv]
// Port-level assertions for the flash operation sequencer.
// Assumes it is bound into flash_op_control_timing and shares its clock.
`timescale 1ns/1ps
`default_nettype none
module flash_op_control_timing_properties
    import flash_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Events and array
    input wire logic irq_o,
    input wire logic pe_start_o,
    input wire logic check_start_o,
    input wire logic rd_busy_o,
    input wire logic rd_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    logic wr_done;
    logic hve_wr;
    logic msk_clr;
    assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
    assign hve_wr = wr_done && paddr_i == OFF_CTRL && pwdata_i[B_HVE];
    assign msk_clr = wr_done && paddr_i == OFF_IRQ_MSK && pwdata_i[2:0] == 3'h0;

    a_pready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("pready held longer than one cycle");
    a_pready_in_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("pready outside an access phase");
    a_apb_one_wait: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
        else $error("apb answer not in second access cycle");
    a_slverr_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    a_mask_off_quiet: assert property (msk_clr |-> ##[1:2] !irq_o)
        else $error("irq stays high with all sources masked");
    a_start_from_ehv: assert property (pe_start_o |-> $past(hve_wr) || $past(hve_wr, 2))
        else $error("program start without enable write");
    a_start_single_pulse: assert property (pe_start_o |=> !pe_start_o)
        else $error("program start pulse too long");
    a_check_single_pulse: assert property (check_start_o |=> !check_start_o)
        else $error("check start pulse too long");
    a_rd_valid_pulse: assert property (rd_valid_o |=> !rd_valid_o)
        else $error("read valid held longer than one cycle");
    a_rd_busy_first: assert property ($rose(rd_valid_o) |-> $past(rd_busy_o))
        else $error("read valid without preceding busy");

    c_irq_raised: cover property ($rose(irq_o));
    c_read_done: cover property (rd_valid_o);
    c_bad_address: cover property (pslverr_o);
endmodule
bind flash_op_control_timing flash_op_control_timing_properties chk (.*);
`default_nettype wire

// [verif/test_flash_op_control_timing.sv]
// Self-checking bench for the flash operation sequencer.
// Assumes the sequencer answers APB with one wait state and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_flash_op_control_timing;
    import flash_seq_pkg::*;
    logic clk_i = 0;
    logic reset_i = 1;
    logic psel_i = 0;
    logic penable_i = 0;
    logic pwrite_i = 0;
    logic [APB_AW-1:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0;
    logic [31:0] prdata_o;
    logic [31:0] rd;
    logic pready_o, pslverr_o, irq_o, err;
    logic array_op_done_i = 0;
    logic check_done_i = 0;
    logic check_break_i = 0;
    logic pe_start_o, pe_halt_o, check_start_o, check_halt_o, low_power_o;
    logic rd_req_i = 0;
    logic rd_busy_o, rd_valid_o;
    logic [23:0] rd_addr_i = 24'h00_0040;
    logic [23:0] array_addr_o;
    logic [63:0] array_rdata_i = '0;
    logic [63:0] rd_data_o;
    int err_count = 0;
    int checks_done = 0;
    int ws [4] = '{0, 2, 3, 4};
    logic address_pipeline_ctrl [4] = '{0, 1, 1, 1};

    flash_op_control_timing uut (.*);

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic results();
        $display("errors=%0d checks=%0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1;
        penable_i <= 0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask

    task automatic st(input logic [31:0] m, input logic [31:0] e);
        apb(0, OFF_STATUS, 32'h0000_0000);
        cmp(rd & m, e);
    endtask

    // Clear events, issue the write, count cycles to the interrupt
    task automatic timed(input logic [7:0] a, input logic [31:0] d, input int lo, input int hi);
        int n;
        n = 0;
        apb(0, OFF_IRQ_STS, 32'h0000_0000);
        apb(1, a, d);
        while (irq_o !== 1'b1 && n < hi + 5) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        cmp(n >= lo && n <= hi, 1);
    endtask

    task automatic rd_chk(input int w);
        int n;
        n = 0;
        @(posedge clk_i);
        rd_req_i <= 1;
        rd_addr_i <= rd_addr_i + 24'h00_0008;
        array_rdata_i <= {32'hCAFE_0000, 32'(w)};
        @(posedge clk_i);
        rd_req_i <= 0;
        while (rd_valid_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        cmp(n, w + 1);
        cmp(rd_data_o, array_rdata_i);
        cmp(array_addr_o, rd_addr_i);
    endtask

    initial begin
        #(25 * 20000);
        err_count++;
        results();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 0;
        st(32'h0000_003F, 32'h0000_0007);
        apb(0, OFF_READCFG, 32'h0000_0000);
        cmp(rd, 32'h0000_000A);
        apb(1, 8'h18, 32'h0000_0001);
        cmp(err, 1);
        apb(1, OFF_IRQ_MSK, 32'h0000_0007);
        apb(1, OFF_CTRL, 32'h0000_0001);
        st(32'h0000_0001, 32'h0000_0000);
        timed(OFF_CTRL, 32'h0000_0003, 380, 464);
        apb(1, OFF_CTRL, 32'h0000_0001);
        st(32'h0000_0001, 32'h0000_0000);
        timed(OFF_CTRL, 32'h0000_0000, 644, 836);
        apb(1, OFF_CTRL, 32'h0000_0001);
        st(32'h0000_0001, 32'h0000_0000);
        timed(OFF_CTRL, 32'h0000_0005, 644, 836);
        timed(OFF_CTRL, 32'h0000_0000, 644, 836);
        apb(1, OFF_CTRL, 32'h0000_0008);
        st(32'h0000_0024, 32'h0000_0020);
        cmp(low_power_o, 1);
        timed(OFF_CTRL, 32'h0000_0000, 647, 1807);
        st(32'h0000_0004, 32'h0000_0004);
        apb(1, OFF_CHECK, 32'h0000_0001);
        st(32'h0000_0002, 32'h0000_0000);
        timed(OFF_CHECK, 32'h0000_0000, 1, 18);
        apb(1, OFF_CHECK, 32'h0000_0001);
        timed(OFF_CHECK, 32'h0000_0003, 1, 18);
        apb(1, OFF_CHECK, 32'h0000_0001);
        st(32'h0000_0002, 32'h0000_0000);
        apb(1, OFF_CHECK, 32'h0000_0005);
        @(posedge clk_i);
        check_break_i <= 1;
        @(posedge clk_i);
        check_break_i <= 0;
        apb(1, OFF_CHECK, 32'h0000_0001);
        st(32'h0000_0002, 32'h0000_0000);
        timed(OFF_CHECK, 32'h0000_0000, 1, 18);
        apb(1, OFF_CHECK, 32'h0000_0009);
        timed(OFF_CHECK, 32'h0000_0008, 419, 820);
        apb(1, OFF_CHECK, 32'h0000_0009);
        timed(OFF_CHECK, 32'h0000_000B, 419, 820);
        apb(1, OFF_IRQ_MSK, 32'h0000_0000);
        @(posedge clk_i);
        #1;
        cmp(irq_o, 0);
        apb(1, OFF_IRQ_MSK, 32'h0000_0007);
        apb(0, OFF_IRQ_STS, 32'h0000_0000);
        cmp(rd[1], 1);
        apb(0, OFF_IRQ_STS, 32'h0000_0000);
        cmp(rd, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            apb(1, OFF_READCFG, {28'h0, address_pipeline_ctrl[i], 3'(ws[i])});
            rd_chk(ws[i]);
        end
        results();
    end
endmodule
`default_nettype wire

// [verilog/flash_delay_timer.sv]
// Down counter that pulses expire a fixed count after a load.
// Assumes load is a one-cycle request; a load of zero cancels.
`timescale 1ns/1ps
`default_nettype none
module flash_delay_timer
    import flash_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control link
    flash_timer_if.tmr tif
);

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic expire;
    } tmr_state_t;

    tmr_state_t s_r;
    tmr_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.expire = 1'b0;
        if (tif.load) begin
            s_nxt.cnt = tif.count;
        end else if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - TMR_W'(1);
            s_nxt.expire = (s_r.cnt == TMR_W'(1));
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tif.expire = s_r.expire;

endmodule
`default_nettype wire

// [verilog/flash_op_control_timing.sv]
// Flash operation sequencer: program/erase and integrity check control.
// Assumes an APB master on clk_i and a flash array macro on the same clock.
//
// Function
// - Program suspend sets op complete after 9.4 us plus four clocks.
// - Erase suspend sets op complete after 16 us plus four clocks.
// - Clearing a suspend bit with high voltage on resumes, clears complete.
// - High voltage enable rising starts operation, clears complete at once.
// - High voltage enable falling aborts; complete after 16 us plus four.
// - Leaving low power takes 16 us plus seven clocks to recover.
// - Check enable rising starts check, clears check complete at once.
// - Clearing check suspend or breakpoint negate resumes, clears check complete.
// - Integrity check abort or suspend sets complete within 80 ns plus fifteen.
// - Margin read abort or suspend sets complete after 10.36 us plus four.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module flash_op_control_timing
    import flash_seq_pkg::*;
#(
    parameter int DATA_W = 64,
    parameter int ADDR_W = 24,
    parameter logic [READ_WAIT_CYCLES_W-1:0] READ_WAIT_CYCLES_RESET = 3'h2,
    parameter logic APC_RESET = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Interrupt
    output logic irq_o,
    // Flash array control
    input wire logic array_op_done_i,
    input wire logic check_done_i,
    input wire logic check_break_i,
    output logic pe_start_o,
    output logic pe_halt_o,
    output logic check_start_o,
    output logic check_halt_o,
    output logic low_power_o,
    // Array read port
    input wire logic rd_req_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    input wire logic [DATA_W-1:0] array_rdata_i,
    output logic [ADDR_W-1:0] array_addr_o,
    output logic rd_busy_o,
    output logic rd_valid_o,
    output logic [DATA_W-1:0] rd_data_o
);

    typedef struct packed {
        op_state_t op;
        ck_state_t ck;
        logic [CTRL_W-1:0] ctrl;
        logic [CHK_W-1:0] chk;
        logic [READ_WAIT_CYCLES_W-1:0] read_wait_cycles;
        logic address_pipeline_ctrl;
        logic done;
        logic aid;
        logic ready;
        logic ck_margin;
        logic [IRQ_W-1:0] irq_sts;
        logic [IRQ_W-1:0] irq_msk;
        logic [IRQ_W-1:0] irq_seen;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic pe_start;
        logic pe_halt;
        logic ck_start;
        logic ck_halt;
        logic lp;
        logic rd_busy;
        logic [READ_WAIT_CYCLES_W-1:0] rd_cnt;
        logic rd_valid;
        logic [DATA_W-1:0] rd_data;
        logic [ADDR_W-1:0] rd_addr;
    } seq_state_t;

    seq_state_t s_r;
    seq_state_t s_nxt;

    flash_timer_if op_tif ();
    flash_timer_if ck_tif ();

    logic op_load;
    logic [TMR_W-1:0] op_count;
    logic ck_load;
    logic [TMR_W-1:0] ck_count;

    function automatic logic hit(input logic [APB_AW-1:0] a, input logic [APB_AW-1:0] off);
        return a == off;
    endfunction

    always_comb begin
        logic acc;
        logic wr;
        logic rd;
        logic [CTRL_W-1:0] cn;
        logic [CHK_W-1:0] kn;
        logic hv_rise;
        logic hv_fall;
        logic sus_clr;
        logic ck_off;
        logic [IRQ_W-1:0] ev;
        logic [31:0] rdat;
        logic mapped;
        acc = psel_i & penable_i;
        wr = acc & s_r.pready & pwrite_i;
        rd = acc & s_r.pready & ~pwrite_i;
        cn = s_r.ctrl;
        kn = s_r.chk;
        ev = '0;
        rdat = '0;
        mapped = 1'b1;
        op_load = 1'b0;
        op_count = '0;
        ck_load = 1'b0;
        ck_count = '0;
        s_nxt = s_r;
        s_nxt.pe_start = 1'b0;
        s_nxt.ck_start = 1'b0;
        s_nxt.rd_valid = 1'b0;

        // Register writes take effect at the completing edge
        if (wr && hit(paddr_i, OFF_CTRL)) begin
            cn = pwdata_i[CTRL_W-1:0];
        end
        if (wr && hit(paddr_i, OFF_CHECK)) begin
            kn = pwdata_i[CHK_W-1:0];
        end
        if (wr && hit(paddr_i, OFF_READCFG)) begin
            s_nxt.read_wait_cycles = pwdata_i[READ_WAIT_CYCLES_W-1:0];
            s_nxt.address_pipeline_ctrl = pwdata_i[B_APC];
        end
        if (wr && hit(paddr_i, OFF_IRQ_MSK)) begin
            s_nxt.irq_msk = pwdata_i[IRQ_W-1:0];
        end
        s_nxt.ctrl = cn;
        s_nxt.chk = kn;

        hv_rise = cn[B_HVE] & ~s_r.ctrl[B_HVE];
        hv_fall = ~cn[B_HVE] & s_r.ctrl[B_HVE];
        sus_clr = (s_r.ctrl[B_PSUS] | s_r.ctrl[B_ESUS]) & ~(cn[B_PSUS] | cn[B_ESUS]);

        // Program/erase sequencing
        unique case (s_r.op)
            OP_IDLE: begin
                if (cn[B_LOWPWR]) begin
                    s_nxt.op = OP_LOWPWR;
                    s_nxt.ready = 1'b0;
                end else if (hv_rise && s_r.ready) begin
                    s_nxt.op = OP_RUN;
                    s_nxt.done = 1'b0;
                    s_nxt.pe_start = 1'b1;
                end
            end
            OP_RUN: begin
                if (hv_fall) begin
                    s_nxt.op = OP_ABORTING;
                    op_load = 1'b1;
                    op_count = ABORT_CYC;
                end else if (cn[B_PSUS] && !s_r.ctrl[B_PSUS]) begin
                    s_nxt.op = OP_SUSPENDING;
                    op_load = 1'b1;
                    op_count = PSUS_CYC;
                end else if (cn[B_ESUS] && !s_r.ctrl[B_ESUS]) begin
                    s_nxt.op = OP_SUSPENDING;
                    op_load = 1'b1;
                    op_count = ESUS_CYC;
                end else if (array_op_done_i) begin
                    s_nxt.op = OP_FINISHED;
                    s_nxt.done = 1'b1;
                end
            end
            OP_SUSPENDING: begin
                if (hv_fall) begin
                    s_nxt.op = OP_ABORTING;
                    op_load = 1'b1;
                    op_count = ABORT_CYC;
                end else if (sus_clr && cn[B_HVE]) begin
                    // Cancel the pending suspend
                    s_nxt.op = OP_RUN;
                    op_load = 1'b1;
                end else if (op_tif.expire) begin
                    s_nxt.op = OP_SUSPENDED;
                    s_nxt.done = 1'b1;
                end
            end
            OP_SUSPENDED: begin
                if (hv_fall) begin
                    s_nxt.op = OP_ABORTING;
                    op_load = 1'b1;
                    op_count = ABORT_CYC;
                end else if (sus_clr && cn[B_HVE]) begin
                    s_nxt.op = OP_RUN;
                    s_nxt.done = 1'b0;
                end
            end
            OP_ABORTING: begin
                if (op_tif.expire) begin
                    s_nxt.op = OP_IDLE;
                    s_nxt.done = 1'b1;
                end
            end
            OP_FINISHED: begin
                if (hv_fall) begin
                    s_nxt.op = OP_IDLE;
                end
            end
            OP_LOWPWR: begin
                if (!cn[B_LOWPWR] && op_tif.expire) begin
                    s_nxt.op = OP_IDLE;
                    s_nxt.ready = 1'b1;
                    ev[E_RECOV] = 1'b1;
                end else if (!cn[B_LOWPWR] && s_r.ctrl[B_LOWPWR]) begin
                    op_load = 1'b1;
                    op_count = RECOVER_CYC;
                end else if (cn[B_LOWPWR]) begin
                    op_load = 1'b1;
                end
            end
        endcase

        // Integrity check and margin read sequencing
        ck_off = ~kn[B_AIE] & s_r.chk[B_AIE];
        unique case (s_r.ck)
            CK_IDLE: begin
                if (kn[B_AIE] && !s_r.chk[B_AIE]) begin
                    s_nxt.ck = CK_RUN;
                    s_nxt.aid = 1'b0;
                    s_nxt.ck_start = 1'b1;
                    s_nxt.ck_margin = kn[B_MARGIN];
                end
            end
            CK_RUN: begin
                if (ck_off || (kn[B_AISUS] && !s_r.chk[B_AISUS])) begin
                    s_nxt.ck = ck_off ? CK_ABORTING : CK_SUSPENDING;
                    ck_load = 1'b1;
                    ck_count = s_r.ck_margin ? MR_STOP_CYC : AI_STOP_CYC - TMR_W'(1);
                end else if (check_break_i && kn[B_INTEGRITY_BREAKPOINT_NEGATE]) begin
                    s_nxt.ck = CK_BREAK;
                    s_nxt.aid = 1'b1;
                end else if (check_done_i) begin
                    s_nxt.ck = CK_FINISHED;
                    s_nxt.aid = 1'b1;
                end
            end
            CK_SUSPENDING: begin
                if (ck_tif.expire) begin
                    s_nxt.ck = CK_SUSPENDED;
                    s_nxt.aid = 1'b1;
                end
            end
            CK_SUSPENDED, CK_BREAK: begin
                if (ck_off) begin
                    s_nxt.ck = CK_ABORTING;
                    ck_load = 1'b1;
                    ck_count = s_r.ck_margin ? MR_STOP_CYC : AI_STOP_CYC - TMR_W'(1);
                end else if ((s_r.ck == CK_SUSPENDED && !kn[B_AISUS])
                             || (s_r.ck == CK_BREAK && !kn[B_INTEGRITY_BREAKPOINT_NEGATE])) begin
                    s_nxt.ck = CK_RUN;
                    s_nxt.aid = 1'b0;
                end
            end
            CK_ABORTING: begin
                if (ck_tif.expire) begin
                    s_nxt.ck = CK_IDLE;
                    s_nxt.aid = 1'b1;
                end
            end
            CK_FINISHED: begin
                if (ck_off) begin
                    s_nxt.ck = CK_IDLE;
                end
            end
        endcase

        s_nxt.pe_halt = s_nxt.op inside {OP_SUSPENDING, OP_SUSPENDED, OP_ABORTING};
        s_nxt.ck_halt = s_nxt.ck inside {CK_SUSPENDING, CK_SUSPENDED, CK_ABORTING, CK_BREAK};
        s_nxt.lp = (s_nxt.op == OP_LOWPWR) && s_nxt.ctrl[B_LOWPWR];

        // Array reads, one clock plus one per wait state
        if (s_r.rd_busy) begin
            if (s_r.rd_cnt == '0) begin
                s_nxt.rd_busy = 1'b0;
                s_nxt.rd_valid = 1'b1;
                s_nxt.rd_data = array_rdata_i;
            end else begin
                s_nxt.rd_cnt = s_r.rd_cnt - READ_WAIT_CYCLES_W'(1);
            end
        end else if (rd_req_i && s_r.ready && (s_r.address_pipeline_ctrl || !s_r.rd_valid)) begin
            s_nxt.rd_busy = 1'b1;
            s_nxt.rd_cnt = s_r.read_wait_cycles;
            s_nxt.rd_addr = rd_addr_i;
        end

        // Sticky events; a new event wins over the read clear
        // Abort from a suspended state re-raises the event with the flag already set
        ev[E_DONE] = (s_nxt.done & ~s_r.done) | ((s_r.op == OP_ABORTING) & op_tif.expire);
        ev[E_AID] = (s_nxt.aid & ~s_r.aid) | ((s_r.ck == CK_ABORTING) & ck_tif.expire);
        s_nxt.irq_sts = s_r.irq_sts;
        if (rd && hit(paddr_i, OFF_IRQ_STS)) begin
            s_nxt.irq_sts = s_r.irq_sts & ~s_r.irq_seen;
        end
        s_nxt.irq_sts = s_nxt.irq_sts | ev;
        s_nxt.irq = |(s_nxt.irq_sts & s_nxt.irq_msk);

        // APB: one wait cycle, read data captured before completion
        unique case (paddr_i)
            OFF_CTRL: rdat[CTRL_W-1:0] = s_r.ctrl;
            OFF_CHECK: rdat[CHK_W-1:0] = s_r.chk;
            OFF_READCFG: rdat[B_APC:0] = {s_r.address_pipeline_ctrl, s_r.read_wait_cycles};
            OFF_IRQ_STS: rdat[IRQ_W-1:0] = s_r.irq_sts;
            OFF_IRQ_MSK: rdat[IRQ_W-1:0] = s_r.irq_msk;
            OFF_STATUS: begin
                rdat[B_DONE] = s_r.done;
                rdat[B_AID] = s_r.aid;
                rdat[B_READY] = s_r.ready;
                rdat[B_OPBUSY] = !(s_r.op inside {OP_IDLE, OP_FINISHED, OP_LOWPWR});
                rdat[B_CKBUSY] = !(s_r.ck inside {CK_IDLE, CK_FINISHED});
                rdat[B_INLP] = s_r.lp;
            end
            default: mapped = 1'b0;
        endcase
        s_nxt.pready = acc & ~s_r.pready;
        if (acc && !s_r.pready) begin
            s_nxt.prdata = rdat;
            s_nxt.pslverr = ~mapped;
            s_nxt.irq_seen = rdat[IRQ_W-1:0];
        end else if (s_r.pready) begin
            s_nxt.pslverr = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_r <= '0;
            s_r.op <= OP_IDLE;
            s_r.ck <= CK_IDLE;
            s_r.done <= 1'b1;
            s_r.aid <= 1'b1;
            s_r.ready <= 1'b1;
            s_r.read_wait_cycles <= READ_WAIT_CYCLES_RESET;
            s_r.address_pipeline_ctrl <= APC_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign op_tif.load = op_load;
    assign op_tif.count = op_count;
    assign ck_tif.load = ck_load;
    assign ck_tif.count = ck_count;

    flash_delay_timer u_op_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .tif(op_tif.tmr)
    );

    flash_delay_timer u_ck_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .tif(ck_tif.tmr)
    );

    assign prdata_o = s_r.prdata;
    assign pready_o = s_r.pready;
    assign pslverr_o = s_r.pslverr;
    assign irq_o = s_r.irq;
    assign pe_start_o = s_r.pe_start;
    assign pe_halt_o = s_r.pe_halt;
    assign check_start_o = s_r.ck_start;
    assign check_halt_o = s_r.ck_halt;
    assign low_power_o = s_r.lp;
    assign array_addr_o = s_r.rd_addr;
    assign rd_busy_o = s_r.rd_busy;
    assign rd_valid_o = s_r.rd_valid;
    assign rd_data_o = s_r.rd_data;

endmodule
`default_nettype wire
